// ### hdl/eeba_pkg.sv
// Purpose: constants for the byte access port of the on-chip data store
// Assumes: 250 MHz cpu clock, i/o register port driven from the same clock
// Notes: all offsets are i/o space indices, all counts in clock cycles

package eeba_pkg;
    // ************************************************************
    // sizes
    // ************************************************************
    localparam int NV_SPACE_BYTES = 4096;
    localparam int ADDR_W = 12;
    localparam int DATA_W = 8;
    localparam int IO_ADDR_W = 6;
    localparam int PROG_CNT_W = 20;
    localparam int HALT_CNT_W = 3;

    // ************************************************************
    // i/o register indices
    // ************************************************************
    localparam logic [5:0] OFS_NV_CONTROL = 6'h1f;
    localparam logic [5:0] OFS_NV_DATA_BYTE = 6'h20;
    localparam logic [5:0] OFS_NV_ADDRESS_LOW = 6'h21;
    localparam logic [5:0] OFS_NV_ADDRESS_HIGH = 6'h22;

    // ************************************************************
    // control register fields
    // ************************************************************
    localparam int BIT_READ_STROBE = 0;
    localparam int BIT_WRITE_STROBE = 1;
    localparam int BIT_MASTER_ENABLE = 2;
    localparam int MODE_LSB = 4;
    localparam int MODE_MSB = 5;
    localparam int ADDR_HIGH_BITS = 4;

    // ************************************************************
    // programming modes
    // ************************************************************
    localparam logic [1:0] MODE_ERASE_WRITE = 2'h0;
    localparam logic [1:0] MODE_ERASE_ONLY = 2'h1;
    localparam logic [1:0] MODE_WRITE_ONLY = 2'h2;
    localparam logic [1:0] MODE_RESERVED = 2'h3;

    // ************************************************************
    // reset values and the erased byte
    // ************************************************************
    localparam logic [7:0] RESET_DATA_BYTE = 8'h00;
    localparam logic [11:0] RESET_ADDRESS = 12'h000;
    localparam logic [1:0] RESET_MODE = 2'h0;
    localparam logic [7:0] ERASED_BYTE = 8'hff;

    // ************************************************************
    // timing
    // ************************************************************
    localparam int CLK_PERIOD_NS = 4;
    localparam int PROG_LONG_NS = 3_400_000;
    localparam int PROG_SHORT_NS = 1_800_000;
    // least times, rounded up to whole cycles
    localparam int PROG_LONG_CYCLES = (PROG_LONG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PROG_SHORT_CYCLES = (PROG_SHORT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [2:0] MASTER_WINDOW_CYCLES = 3'h4;
    localparam logic [2:0] READ_HALT_CYCLES = 3'h4;
    localparam logic [2:0] WRITE_HALT_CYCLES = 3'h2;
endpackage

// ### hdl/eeba_array.sv
// Purpose: 4K byte storage array, one port, registered read data
// Assumes: one access per cycle, write wins over read
// Notes: contents are not reset, as in a real nonvolatile store
`timescale 1ns/1ps

module eeba_array
    import eeba_pkg::*;
(
    // clock
    input wire logic clock,
    // access port
    input wire logic enable,
    input wire logic write_en,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] wdata,
    output logic [DATA_W-1:0] rdata
);
    // the byte cells
    logic [DATA_W-1:0] cells [NV_SPACE_BYTES];

    // single byte write or read per access
    always_ff @(posedge clock) begin
        if (enable && write_en) begin
            cells[addr] <= wdata;
        end else if (enable) begin
            rdata <= cells[addr];
        end
    end
endmodule // eeba_array

// ### hdl/eeba_prog_timer.sv
// Purpose: self-timed programming period counter
// Assumes: start is a one-cycle pulse, load_count at least 1
// Notes: done is a one-cycle pulse at the end of the period
`timescale 1ns/1ps

module eeba_prog_timer
    import eeba_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // control
    input wire logic start,
    input wire logic [PROG_CNT_W-1:0] load_count,
    output logic done
);
    logic [PROG_CNT_W-1:0] count; // cycles left
    logic [PROG_CNT_W-1:0] next_count;
    logic next_done;

    // count down, flag the last cycle
    always_comb begin
        next_count = count;
        next_done = 1'b0;
        if (start) begin
            next_count = load_count;
        end else if (count != '0) begin
            next_count = count - 1'b1;
            next_done = (count == 20'h0_0001);
        end
    end

    // state registers
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            count <= '0;
            done <= 1'b0;
        end else begin
            count <= next_count;
            done <= next_done;
        end
    end
endmodule // eeba_prog_timer

// ### hdl/eeba_port.sv
// Purpose: cpu i/o register port to the 4K byte data store
// Assumes: io_* come from cpu logic on the same clock
// Notes: cpu_halt stretches the instruction after a trigger
`timescale 1ns/1ps

module eeba_port
    import eeba_pkg::*;
#(
    parameter int PROG_LONG = PROG_LONG_CYCLES,
    parameter int PROG_SHORT = PROG_SHORT_CYCLES
)
(
    // clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // cpu i/o register port
    input wire logic [IO_ADDR_W-1:0] io_addr,
    input wire logic io_wr,
    input wire logic io_rd,
    input wire logic [DATA_W-1:0] io_wdata,
    output logic [DATA_W-1:0] io_rdata,
    // cpu stall
    output logic cpu_halt
);
    // ************************************************************
    // reset release
    // ************************************************************
    logic rst_meta_n; // first stage, read only by rst_n
    logic rst_n; // synchronised release used below

    // async assert, clocked release
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            rst_meta_n <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta_n <= 1'b1;
            rst_n <= rst_meta_n;
        end
    end

    // ************************************************************
    // declarations
    // ************************************************************
    typedef enum logic [2:0] {
        st_idle,
        st_load,
        st_fetch,
        st_program,
        st_commit
    } eeba_state_t;

    eeba_state_t state, next_state;
    logic [DATA_W-1:0] nv_data_byte, next_nv_data_byte;
    logic [ADDR_W-1:0] nv_address_field, next_nv_address_field;
    logic [1:0] program_mode_field, next_program_mode_field;
    logic master_write_enable, next_master_write_enable;
    logic [2:0] master_count, next_master_count;
    logic write_strobe, next_write_strobe;
    // operands latched at the write trigger
    logic [ADDR_W-1:0] prog_addr, next_prog_addr;
    logic [DATA_W-1:0] prog_data, next_prog_data;
    logic [1:0] prog_mode, next_prog_mode;
    logic [DATA_W-1:0] old_byte, next_old_byte;
    // cpu stall
    logic [HALT_CNT_W-1:0] halt_count, next_halt_count;
    logic next_cpu_halt;
    logic [DATA_W-1:0] next_io_rdata;
    // decoded accesses
    logic wr_control, wr_data, wr_addr_low, wr_addr_high;
    logic start_write, start_read;
    // array port
    logic mem_en, mem_we;
    logic [ADDR_W-1:0] mem_addr;
    logic [DATA_W-1:0] mem_wdata, mem_rdata;
    // timer
    logic timer_start, timer_done;
    logic [PROG_CNT_W-1:0] timer_load;

    // ************************************************************
    // i/o decode
    // ************************************************************
    // one strobe per register
    always_comb begin
        wr_control = io_wr && (io_addr == OFS_NV_CONTROL);
        wr_data = io_wr && (io_addr == OFS_NV_DATA_BYTE);
        wr_addr_low = io_wr && (io_addr == OFS_NV_ADDRESS_LOW);
        wr_addr_high = io_wr && (io_addr == OFS_NV_ADDRESS_HIGH);
        // write needs master enable still open and an idle store
        start_write = wr_control && io_wdata[BIT_WRITE_STROBE]
            && master_write_enable && !write_strobe && (state == st_idle);
        // reads are refused while a write is in flight
        start_read = wr_control && io_wdata[BIT_READ_STROBE]
            && !start_write && !write_strobe && (state == st_idle);
    end

    // ************************************************************
    // registers seen by software
    // ************************************************************
    // address, data, mode and master enable next values
    always_comb begin
        next_nv_address_field = nv_address_field;
        next_nv_data_byte = nv_data_byte;
        next_program_mode_field = program_mode_field;
        next_master_write_enable = master_write_enable;
        next_master_count = master_count;
        // address frozen while programming
        if (wr_addr_low && !write_strobe) begin
            next_nv_address_field[7:0] = io_wdata;
        end
        // only the low nibble of the high byte is stored
        if (wr_addr_high && !write_strobe) begin
            next_nv_address_field[ADDR_W-1:8] = io_wdata[ADDR_HIGH_BITS-1:0];
        end
        // completed read wins over a software write
        if (state == st_load) begin
            next_nv_data_byte = mem_rdata;
        end else if (wr_data) begin
            next_nv_data_byte = io_wdata;
        end
        // mode writes ignored while busy
        if (wr_control && !write_strobe && !start_write) begin
            next_program_mode_field = io_wdata[MODE_MSB:MODE_LSB];
        end
        // master enable closes by itself after its window
        if (master_write_enable) begin
            next_master_count = master_count - 1'b1;
            if (master_count == 3'h1) begin
                next_master_write_enable = 1'b0;
            end
        end
        // a fresh set restarts the window, consumed by a start
        if (start_write) begin
            next_master_write_enable = 1'b0;
            next_master_count = '0;
        end else if (wr_control && io_wdata[BIT_MASTER_ENABLE]) begin
            next_master_write_enable = 1'b1;
            next_master_count = MASTER_WINDOW_CYCLES;
        end
    end

    // software-visible register bank
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            nv_address_field <= RESET_ADDRESS;
            nv_data_byte <= RESET_DATA_BYTE;
            program_mode_field <= RESET_MODE;
            master_write_enable <= 1'b0;
            master_count <= '0;
        end else begin
            nv_address_field <= next_nv_address_field;
            nv_data_byte <= next_nv_data_byte;
            program_mode_field <= next_program_mode_field;
            master_write_enable <= next_master_write_enable;
            master_count <= next_master_count;
        end
    end

    // ************************************************************
    // access sequencer
    // ************************************************************
    // read, fetch old byte, time, commit
    always_comb begin
        next_state = state;
        next_write_strobe = write_strobe;
        next_prog_addr = prog_addr;
        next_prog_data = prog_data;
        next_prog_mode = prog_mode;
        next_old_byte = old_byte;
        mem_en = 1'b0;
        mem_we = 1'b0;
        mem_addr = nv_address_field;
        mem_wdata = prog_data;
        timer_start = 1'b0;
        timer_load = PROG_CNT_W'(PROG_SHORT);
        unique case (state)
            st_idle: begin
                if (start_write) begin
                    // latch operands, later register writes cannot corrupt it
                    next_prog_addr = nv_address_field;
                    next_prog_data = nv_data_byte;
                    next_prog_mode = program_mode_field;
                    next_write_strobe = 1'b1;
                    mem_en = 1'b1; // old byte for write-only mode
                    next_state = st_fetch;
                end else if (start_read) begin
                    mem_en = 1'b1;
                    next_state = st_load;
                end
            end
            st_load: begin
                // data byte loaded from registered array output
                next_state = st_idle;
            end
            st_fetch: begin
                next_old_byte = mem_rdata;
                timer_start = 1'b1;
                if (prog_mode == MODE_ERASE_WRITE) begin
                    timer_load = PROG_CNT_W'(PROG_LONG);
                end
                next_state = st_program;
            end
            st_program: begin
                // strobe held high for the whole period
                if (timer_done) begin
                    next_state = st_commit;
                end
            end
            st_commit: begin
                mem_addr = prog_addr;
                mem_en = (prog_mode != MODE_RESERVED); // reserved: no change
                mem_we = 1'b1;
                // erase sets every bit, write only can only clear bits
                unique case (prog_mode)
                    MODE_ERASE_ONLY: mem_wdata = ERASED_BYTE;
                    MODE_WRITE_ONLY: mem_wdata = old_byte & prog_data;
                    default: mem_wdata = prog_data;
                endcase
                next_write_strobe = 1'b0;
                next_state = st_idle;
            end
        endcase
        if (state == st_fetch) begin
            mem_addr = prog_addr;
        end
    end

    // sequencer registers
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state <= st_idle;
            write_strobe <= 1'b0;
            prog_addr <= RESET_ADDRESS;
            prog_data <= RESET_DATA_BYTE;
            prog_mode <= RESET_MODE;
            old_byte <= RESET_DATA_BYTE;
        end else begin
            state <= next_state;
            write_strobe <= next_write_strobe;
            prog_addr <= next_prog_addr;
            prog_data <= next_prog_data;
            prog_mode <= next_prog_mode;
            old_byte <= next_old_byte;
        end
    end

    // ************************************************************
    // cpu stall and read-back
    // ************************************************************
    // halt counter loaded by accepted triggers
    always_comb begin
        next_halt_count = halt_count;
        if (start_read) begin
            next_halt_count = READ_HALT_CYCLES;
        end else if (start_write) begin
            next_halt_count = WRITE_HALT_CYCLES;
        end else if (halt_count != '0) begin
            next_halt_count = halt_count - 1'b1;
        end
        next_cpu_halt = (next_halt_count != '0);
        // read mux, reserved bits read zero
        next_io_rdata = '0;
        if (io_rd) begin
            unique case (io_addr)
                OFS_NV_CONTROL: begin
                    next_io_rdata[MODE_MSB:MODE_LSB] = program_mode_field;
                    next_io_rdata[BIT_MASTER_ENABLE] = master_write_enable;
                    next_io_rdata[BIT_WRITE_STROBE] = write_strobe;
                end
                OFS_NV_DATA_BYTE: next_io_rdata = nv_data_byte;
                OFS_NV_ADDRESS_LOW: next_io_rdata = nv_address_field[7:0];
                // upper nibble forced to zero
                OFS_NV_ADDRESS_HIGH: next_io_rdata = {4'h0, nv_address_field[ADDR_W-1:8]};
                default: next_io_rdata = '0; // other i/o space not ours
            endcase
        end
    end

    // stall and read-back registers
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            halt_count <= '0;
            cpu_halt <= 1'b0;
            io_rdata <= '0;
        end else begin
            halt_count <= next_halt_count;
            cpu_halt <= next_cpu_halt;
            io_rdata <= next_io_rdata;
        end
    end

    // ************************************************************
    // storage and timer
    // ************************************************************
    // byte array, single byte per access
    eeba_array u_array (
        .clock(clock),
        .enable(mem_en),
        .write_en(mem_we),
        .addr(mem_addr),
        .wdata(mem_wdata),
        .rdata(mem_rdata)
    );

    // programming period
    eeba_prog_timer u_timer (
        .clock(clock),
        .reset_n(rst_n),
        .start(timer_start),
        .load_count(timer_load),
        .done(timer_done)
    );
endmodule // eeba_port

// ### testbench/eeba_port_chk.sv
// Purpose: port checks for the data store access port
// Assumes: one clock, reset_n low clears the port
// Notes: master window is tracked from bus writes only
`timescale 1ns/1ps

module eeba_port_chk
    import eeba_pkg::*;
#(
    parameter int PROG_LONG = PROG_LONG_CYCLES,
    parameter int PROG_SHORT = PROG_SHORT_CYCLES
)
(
    // clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // cpu i/o register port
    input wire logic [IO_ADDR_W-1:0] io_addr,
    input wire logic io_wr,
    input wire logic io_rd,
    input wire logic [DATA_W-1:0] io_wdata,
    input wire logic [DATA_W-1:0] io_rdata,
    // cpu stall
    input wire logic cpu_halt
);
    // ************************************************************
    // helper logic
    // ************************************************************
    logic [2:0] win; // cycles left in master window
    logic [2:0] next_win; // next window count
    logic ctl_wr; // write to control register
    assign ctl_wr = io_wr && (io_addr == OFS_NV_CONTROL);
    // any master bit write reopens, so an open guess is never too short
    always_comb begin
        next_win = (win != 3'h0) ? win - 3'h1 : 3'h0;
        if (ctl_wr && io_wdata[BIT_MASTER_ENABLE]) begin
            next_win = MASTER_WINDOW_CYCLES;
        end
    end
    // register the window count
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            win <= 3'h0;
        end else begin
            win <= next_win;
        end
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (!reset_n);
    // ************************************************************
    // assertions
    // ************************************************************
    idle_rdata_a: assert property (
        !io_rd |=> io_rdata == 8'h00) else $error("read data not zero without a read");
    addr_high_a: assert property (
        io_rd && io_addr == OFS_NV_ADDRESS_HIGH |=> io_rdata[7:4] == 4'h0) else $error("address high nibble");
    ctrl_resv_a: assert property (
        io_rd && io_addr == OFS_NV_CONTROL |=> io_rdata[7:6] == 2'h0 && io_rdata[3] == 1'b0
        && io_rdata[0] == 1'b0) else $error("control reserved bits not zero");
    unmapped_zero_a: assert property (
        io_rd && !(io_addr inside {[OFS_NV_CONTROL:OFS_NV_ADDRESS_HIGH]}) |=> io_rdata == 8'h00)
        else $error("unmapped read not zero");
    halt_len_a: assert property (
        $rose(cpu_halt) |-> (cpu_halt [*2] ##1 !cpu_halt) or (cpu_halt [*4] ##1 !cpu_halt))
        else $error("halt length not two or four");
    halt_cause_a: assert property (
        $rose(cpu_halt) |-> $past(ctl_wr)) else $error("halt without control write");
    strobe_locked_a: assert property (
        ctl_wr && io_wdata == 8'h02 && win == 3'h0 |=> !$rose(cpu_halt)) else $error("strobe ran without master");
    data_keep_a: assert property (
        io_wr && io_addr == OFS_NV_DATA_BYTE && !cpu_halt ##2 io_rd && io_addr == OFS_NV_DATA_BYTE
        |=> io_rdata == $past(io_wdata, 3)) else $error("data byte not kept");
    // ************************************************************
    // covers
    // ************************************************************
    read_halt_c: cover property ($rose(cpu_halt) ##3 cpu_halt);
    write_halt_c: cover property ($rose(cpu_halt) ##2 !cpu_halt);
    refused_c: cover property (ctl_wr && io_wdata == 8'h02 && win == 3'h0);
endmodule // eeba_port_chk

// ### testbench/tb_eeba_port.sv
// Purpose: self-checking bench for the data store access port
// Assumes: short program times, inputs change on falling edges
// Notes: expected bytes come from the mode table, not the array
`timescale 1ns/1ps

module tb_eeba_port
    import eeba_pkg::*;
;
    // ************************************************************
    // signals
    // ************************************************************
    localparam int P_LONG = 30; // shortened so runs stay brief
    localparam int P_SHORT = 16;
    logic clock = 1'b0;
    logic reset_n = 1'b0; // held low at start
    logic [IO_ADDR_W-1:0] io_addr = 6'h00;
    logic io_wr = 1'b0;
    logic io_rd = 1'b0;
    logic [DATA_W-1:0] io_wdata = 8'h00;
    logic [DATA_W-1:0] io_rdata;
    logic cpu_halt;
    int fail_count = 0;
    int samples_checked = 0;
    // table: address, mode, data, expected byte
    logic [11:0] t_addr [5] = '{12'habc, 12'habc, 12'hfff, 12'habc, 12'hfff};
    logic [1:0] t_mode [5] = '{MODE_ERASE_WRITE, MODE_WRITE_ONLY, MODE_ERASE_WRITE, MODE_ERASE_ONLY, MODE_RESERVED};
    logic [7:0] t_data [5] = '{8'h5a, 8'h3c, 8'ha5, 8'h00, 8'h00};
    logic [7:0] t_exp [5] = '{8'h5a, 8'h18, 8'ha5, ERASED_BYTE, 8'ha5};
    always #2 clock = ~clock;
    eeba_port #(.PROG_LONG(P_LONG), .PROG_SHORT(P_SHORT)) eeba_port_i (.clock(clock), .reset_n(reset_n),
        .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata),
        .cpu_halt(cpu_halt));
    // ************************************************************
    // tasks
    // ************************************************************
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD t=%0t got %h want %h", $time, got, exp);
        end
    endtask
    // one write pulse, taken at the rising edge in between
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(negedge clock);
        io_addr = a;
        io_wdata = d;
        io_wr = 1'b1;
        @(negedge clock);
        io_wr = 1'b0;
    endtask
    // read data is registered, so it is settled at the next falling edge
    task automatic rd_chk(input logic [5:0] a, input logic [7:0] exp);
        @(negedge clock);
        io_addr = a;
        io_rd = 1'b1;
        @(negedge clock);
        io_rd = 1'b0;
        check(io_rdata, exp);
    endtask
    // count stall cycles seen over six cycles after a trigger
    task automatic halt_chk(input int exp);
        int n = 0;
        for (int i = 0; i < 6; i++) begin
            if (cpu_halt === 1'b1) begin
                n++;
            end
            @(negedge clock);
        end
        check(8'(n), 8'(exp));
    endtask
    // poll the busy bit over the port with a bound, a hang shows as a mismatch
    task automatic wait_idle();
        int n = 0;
        logic busy = 1'b1;
        while (busy && n < 100) begin
            @(negedge clock);
            io_addr = OFS_NV_CONTROL;
            io_rd = 1'b1;
            @(negedge clock);
            io_rd = 1'b0;
            busy = io_rdata[BIT_WRITE_STROBE];
            n++;
        end
        check(8'(n < 100), 8'h01);
    endtask
    task automatic write_byte(input logic [11:0] a, input logic [1:0] mode, input logic [7:0] d,
        input logic [7:0] exp);
        logic [7:0] m = {2'b00, mode, 4'h0};
        wr(OFS_NV_ADDRESS_HIGH, {4'h0, a[11:8]});
        wr(OFS_NV_ADDRESS_LOW, a[7:0]);
        wr(OFS_NV_DATA_BYTE, d);
        wr(OFS_NV_CONTROL, m | 8'h04);
        wr(OFS_NV_CONTROL, m | 8'h06);
        halt_chk(2);
        rd_chk(OFS_NV_CONTROL, m | 8'h02);
        wr(OFS_NV_ADDRESS_LOW, ~a[7:0]);
        // read trigger while busy must be ignored, this write repeats the same mode bits
        wr(OFS_NV_CONTROL, m | 8'h01);
        halt_chk(0);
        wait_idle();
        rd_chk(OFS_NV_CONTROL, m);
        rd_chk(OFS_NV_ADDRESS_LOW, a[7:0]);
        wr(OFS_NV_DATA_BYTE, 8'h00);
        wr(OFS_NV_CONTROL, 8'h01);
        halt_chk(4);
        rd_chk(OFS_NV_DATA_BYTE, exp);
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // ************************************************************
    // main sequence
    // ************************************************************
    initial begin
        repeat (6) @(negedge clock);
        reset_n = 1'b1;
        repeat (3) @(negedge clock);
        rd_chk(OFS_NV_DATA_BYTE, RESET_DATA_BYTE);
        rd_chk(OFS_NV_ADDRESS_LOW, 8'h00);
        rd_chk(OFS_NV_CONTROL, 8'h00);
        rd_chk(6'h30, 8'h00);
        wr(OFS_NV_ADDRESS_HIGH, 8'hff);
        rd_chk(OFS_NV_ADDRESS_HIGH, 8'h0f);
        wr(OFS_NV_DATA_BYTE, 8'h77);
        rd_chk(OFS_NV_DATA_BYTE, 8'h77);
        // strobe alone, then strobe after the window ran out
        wr(OFS_NV_CONTROL, 8'h02);
        halt_chk(0);
        rd_chk(OFS_NV_CONTROL, 8'h00);
        wr(OFS_NV_CONTROL, 8'h04);
        rd_chk(OFS_NV_CONTROL, 8'h04);
        // strobe lands on the fifth cycle after the set, just outside the window
        @(negedge clock);
        wr(OFS_NV_CONTROL, 8'h02);
        halt_chk(0);
        rd_chk(OFS_NV_CONTROL, 8'h00);
        for (int i = 0; i < 5; i++) begin
            write_byte(t_addr[i], t_mode[i], t_data[i], t_exp[i]);
        end
        print_verdict();
    end
    // watchdog, far beyond the expected run length
    initial begin
        repeat (20000) @(negedge clock);
        fail_count++;
        $display("BAD t=%0t watchdog expired", $time);
        print_verdict();
    end
endmodule // tb_eeba_port

bind eeba_port eeba_port_chk #(.PROG_LONG(PROG_LONG), .PROG_SHORT(PROG_SHORT)) eeba_port_chk_i (.clock(clock),
    .reset_n(reset_n), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata),
    .io_rdata(io_rdata), .cpu_halt(cpu_halt));
